// *** pkg/card_regs_pkg.sv ***
package card_regs_pkg;

	localparam int         NUM_CHANNELS    = 4;
	localparam int         CODE_WIDTH      = 12;
	localparam int         ADDR_WIDTH      = 5;
	localparam int         DATA_WIDTH      = 8;
	localparam int         ID_WIDTH        = 4;
	// Byte offsets in the card's I/O space
	localparam logic [4:0] OFS_CODE_BASE   = 5'h00;
	localparam logic [4:0] OFS_CODE_LAST   = 5'h07;
	localparam logic [4:0] OFS_RANGE       = 5'h08;
	localparam logic [4:0] OFS_CARD_NUMBER = 5'h14;
	// Range field: two bits per channel, span low, bipolar high
	localparam int         RANGE_SPAN_BIT  = 0;
	localparam int         RANGE_BIP_BIT   = 1;
	localparam int         RANGE_FIELD_W   = 2;
	// Default: 0 to +5 V, code for zero volts
	localparam logic [7:0]  RANGE_DEFAULT  = 8'h00;
	localparam logic [11:0] CODE_DEFAULT   = 12'h000;
	localparam logic [3:0]  CODE_HIGH_MASK = 4'hf;

endpackage : card_regs_pkg

// *** verification/board_id_and_reset_retention_asserts.sv ***
`timescale 1ns/1ps
module card_chk import card_regs_pkg::*; (input wire logic clk, resetn, ce, warmResetn,
	retentionJumper, wrStrobe, rdStrobe, input wire logic [3:0] cardNumberSwitch,
	input wire logic [4:0] addr, input wire logic [7:0] wrData, rdData, rangeSel,
	input wire logic [47:0] outCode);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire w = ce && wrStrobe && warmResetn, h = ce && !warmResetn && !wrStrobe;
	wire r = ce && rdStrobe && !wrStrobe, d = addr == OFS_CARD_NUMBER, g = addr == OFS_RANGE;
	// Jumper history: the design only honours a jumper that has settled through its synchroniser
	logic [3:0] jHist;
	always_ff @(posedge clk) if (ce) jHist <= {jHist[2:0], retentionJumper};
	wire jOk = (jHist == {4{retentionJumper}});
	wire k = h && retentionJumper && jOk, c = h && !retentionJumper && jOk;
	wire [55:0] s = {rangeSel, outCode};
	AST_KEEP: assert property (k |=> $stable(s)) else $error("kept");
	AST_CLR: assert property (c |=> s == 56'h0) else $error("clr");
	AST_PWR: assert property ($rose(resetn) |-> s == 56'h0) else $error("pwr");
	AST_ID: assert property ((ce && $stable(cardNumberSwitch))[*8] ##0 (r && d) |=>
		rdData[3:0] == ~$past(cardNumberSwitch)) else $error("id");
	AST_HI: assert property (r && d |=> rdData[7:4] == 4'h0) else $error("hi");
	AST_IW: assert property (w && d |=> $stable(s)) else $error("iw");
	AST_RW: assert property (w && g |=> rangeSel == $past(wrData)) else $error("rw");
	AST_RR: assert property (r && g |=> rdData == $past(rangeSel)) else $error("rr");
	AST_FRZ: assert property (!ce |=> $stable(s) && $stable(rdData)) else $error("frz");
	cover property (!ce && wrStrobe);
	cover property (k);
	cover property (c);
	cover property (r && d);
endmodule : card_chk
bind board_id_and_reset_retention card_chk i_card_chk (.*);

// *** verification/host_model.sv ***
`timescale 1ns/1ps
module host_model (input wire logic clk, output logic [4:0] addr = '0,
	output logic [7:0] wrData = '0, output logic wrStrobe = 1'b0, rdStrobe = 1'b0);
	task automatic acc(logic w, logic [4:0] a, logic [7:0] d);
		@(posedge clk) {wrStrobe, rdStrobe, addr, wrData} <= {w, !w, a, d};
		// Released data shows the inverse so a stale byte cannot pass
		@(posedge clk) {wrStrobe, rdStrobe, wrData} <= {2'b0, ~d};
	endtask : acc
endmodule : host_model

// *** verification/tb_board_id_and_reset_retention.sv ***
`timescale 1ns/1ps
module tb_board_id_and_reset_retention import card_regs_pkg::*;;
	logic clk = 0, resetn = 0, ce = 1, warmResetn = 1, retentionJumper = 0, wrStrobe, rdStrobe;
	logic [3:0] cardNumberSwitch = 4'hf;
	logic [4:0] addr;
	logic [7:0] wrData, rdData, rangeSel;
	logic [47:0] outCode;
	int error_cnt, checked;
	always #25 clk = ~clk;
	board_id_and_reset_retention i_board_id_and_reset_retention (.*);
	host_model i_host_model (.*);
	task cmp(string n, logic [55:0] e, g);
		checked++;
		if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
		error_cnt += int'(g !== e);
	endtask : cmp
	task rst(logic p, j, logic [55:0] e);
		@(posedge clk) retentionJumper <= j;
		// Let the jumper settle through the design's synchroniser first
		repeat (5) @(posedge clk);
		{resetn, warmResetn} <= {!p, p};
		repeat (3) @(posedge clk);
		{resetn, warmResetn} <= 2'b11;
		repeat (2) @(posedge clk);
		#1 cmp("state", e, {rangeSel, outCode});
	endtask : rst
	task t_id;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk) cardNumberSwitch <= ~4'(k);
			repeat (6) @(posedge clk);
			i_host_model.acc(1, OFS_CARD_NUMBER, 8'hff);
			i_host_model.acc(0, OFS_CARD_NUMBER, 8'h00);
			#1 cmp("id", 56'(k), 56'(rdData));
		end
		$display("id done");
	endtask : t_id
	task t_keep;
		i_host_model.acc(1, OFS_RANGE, RANGE_DEFAULT);
		i_host_model.acc(1, OFS_CODE_BASE, 8'h34);
		i_host_model.acc(1, 5'h01, 8'h0a);
		i_host_model.acc(1, OFS_RANGE, 8'hb4);
		rst(0, 1, {8'hb4, 36'h0, 12'ha34});
		i_host_model.acc(0, OFS_RANGE, 8'h00);
		#1 cmp("range", 56'hb4, 56'(rdData));
		rst(1, 1, 56'h0);
		i_host_model.acc(1, OFS_RANGE, 8'h5a);
		rst(0, 0, 56'h0);
		$display("keep done");
	endtask : t_keep
	task t_freeze;
		@(posedge clk) ce <= 1'b0;
		i_host_model.acc(1, OFS_RANGE, 8'h33);
		@(posedge clk) ce <= 1'b1;
		i_host_model.acc(0, OFS_RANGE, 8'h00);
		#1 cmp("freeze", 56'h0, 56'(rdData));
		$display("freeze done");
	endtask : t_freeze
	task end_of_test;
		$display("checks %0d bad %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1;
		t_id;
		t_keep;
		t_freeze;
		end_of_test;
	end
endmodule : tb_board_id_and_reset_retention

// *** verilog/board_id_and_reset_retention.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Retention jumper fitted: warm reset keeps ranges and output codes unchanged.
// [RULE_02] Power loss clears ranges and codes regardless of the jumper.
// [RULE_03] Default state: every channel 0 to 5 V, every output code zero volts.
// [RULE_04] Jumper not fitted: warm reset and power-off both restore defaults.
// [RULE_05] Switch position k drives identifier bit k; ON gives 0, OFF gives 1.
// [RULE_06] Read at byte offset 20 returns identifier in bits 3..0.
// [RULE_07] All switches ON as shipped reads identifier zero.
// [RULE_08] Host sets a channel to 0 to 5 V before using its current sink.
// [RULE_09] Range register at offset 8 holds bipolar and span bits per channel.
// [RULE_10] Identifier bits 7..4 read zero; writes to it are ignored.
module board_id_and_reset_retention
	import card_regs_pkg::*;
(
	input  wire logic                   clk,           // Bus clock, 20 MHz
	input  wire logic                   resetn,        // Power-on reset, async, active low
	input  wire logic                   ce,            // Clock enable, freezes state when low
	input  wire logic                   warmResetn,    // Host warm reset, active low, synchronous
	input  wire logic                   retentionJumper, // High when retention jumper fitted
	input  wire logic [ID_WIDTH-1:0]    cardNumberSwitch, // Switch positions, high = ON
	input  wire logic [ADDR_WIDTH-1:0]  addr,          // Byte offset from base
	input  wire logic                   wrStrobe,      // One-cycle write request
	input  wire logic                   rdStrobe,      // One-cycle read request
	input  wire logic [DATA_WIDTH-1:0]  wrData,        // Write data byte
	output logic      [DATA_WIDTH-1:0]  rdData,        // Read data byte, registered
	output logic      [NUM_CHANNELS*RANGE_FIELD_W-1:0] rangeSel, // Per-channel range bits
	output logic      [NUM_CHANNELS*CODE_WIDTH-1:0]    outCode   // Per-channel output codes
);

	// Bytes per channel code word, low byte at the even offset
	localparam int          CODE_BYTES = 2;
	// Bits of a code carried by the high byte
	localparam int          HIGH_W     = CODE_WIDTH - DATA_WIDTH;
	// Width of the packed range field
	localparam int          RANGE_W    = NUM_CHANNELS * RANGE_FIELD_W;

	// Synchroniser reset values match an all-ON switch and an absent jumper
	localparam logic [ID_WIDTH-1:0] SW_IDLE  = '0;
	localparam logic                JMP_IDLE = 1'b0;

	// Switch path: mechanical and asynchronous to the bus clock
	logic [ID_WIDTH-1:0]    swSync1;
	logic [ID_WIDTH-1:0]    swSync2;
	logic [ID_WIDTH-1:0]    swSync3;
	logic [ID_WIDTH-1:0]    cardNumber;
	// Jumper path: a strap, but nothing stops it being moved with power on
	logic                   jmpSync1;
	logic                   jmpSync2;
	logic                   jmpSync3;
	logic                   retainOn;
	// Per-channel storage, flattened onto outCode below
	logic [CODE_WIDTH-1:0]  codeReg     [NUM_CHANNELS];
	logic [DATA_WIDTH-1:0]  lowByteHold [NUM_CHANNELS];
	logic [DATA_WIDTH-1:0]  next_rdData;

	// Address decode
	wire                    selRange   = (addr == OFS_RANGE);
	wire                    selCardId  = (addr == OFS_CARD_NUMBER);
	wire                    wrRange    = wrStrobe && selRange;
	wire                    rdTaken    = ce && rdStrobe;

	// Synchroniser agreement
	wire                    swAgree    = (swSync2 == swSync3);
	wire                    jmpAgree   = (jmpSync2 == jmpSync3);

	// ON pulls a position high and reads as a zero bit
	wire [ID_WIDTH-1:0]     swInverted = ~cardNumberSwitch; // [RULE_05] [RULE_07]

	// resetn is power loss and always clears; warm reset clears only with retention off
	wire                    warmReset  = !warmResetn;
	wire                    clearState = warmReset && !retainOn; // [RULE_01] [RULE_04]

	// Upper identifier bits are zero by extension; no write path reaches cardNumber
	wire [DATA_WIDTH-1:0]   idReadValue = DATA_WIDTH'(cardNumber); // [RULE_10]

	// Range register: a warm clear beats a write in the same cycle
	wire [RANGE_W-1:0]      next_rangeSel = clearState ? RANGE_DEFAULT :
	                                        wrRange    ? wrData :
	                                        rangeSel;

	// Switch synchroniser, first stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swSync1 <= SW_IDLE;
		end else if (ce) begin
			swSync1 <= swInverted;
		end
	end

	// Only stage 2 reads stage 1, so a metastable sample never reaches the compare
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swSync2 <= SW_IDLE;
		end else if (ce) begin
			swSync2 <= swSync1;
		end
	end

	// Third stage only feeds the agreement check
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swSync3 <= SW_IDLE;
		end else if (ce) begin
			swSync3 <= swSync2;
		end
	end

	// A new setting counts once stages 2 and 3 agree, so a half-settled sample is not taken
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cardNumber <= SW_IDLE;
		end else if (ce && swAgree) begin
			cardNumber <= swSync2; // [RULE_05]
		end
	end

	// Jumper synchroniser, same three stages as the switch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			jmpSync1 <= JMP_IDLE;
		end else if (ce) begin
			jmpSync1 <= retentionJumper;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			jmpSync2 <= JMP_IDLE;
		end else if (ce) begin
			jmpSync2 <= jmpSync1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			jmpSync3 <= JMP_IDLE;
		end else if (ce) begin
			jmpSync3 <= jmpSync2;
		end
	end

	// Retention takes effect a few cycles after the jumper moves; a limitation for hot changes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			retainOn <= JMP_IDLE;
		end else if (ce && jmpAgree) begin
			retainOn <= jmpSync2; // [RULE_01]
		end
	end

	// Range settings; power loss always restores the default
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rangeSel <= RANGE_DEFAULT; // [RULE_02] [RULE_03]
		end else if (ce) begin
			rangeSel <= next_rangeSel; // [RULE_09]
		end
	end

	// One storage slice per channel
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			localparam logic [ADDR_WIDTH-1:0] LO_OFS = OFS_CODE_BASE + ADDR_WIDTH'(CODE_BYTES * ch);
			localparam logic [ADDR_WIDTH-1:0] HI_OFS = LO_OFS + ADDR_WIDTH'(1);

			wire                    addrLo     = (addr == LO_OFS);
			wire                    addrHi     = (addr == HI_OFS);
			wire                    wrLow      = wrStrobe && addrLo;
			wire                    wrHigh     = wrStrobe && addrHi;

			// High byte carries the top bits; the rest of that byte is unused
			wire [HIGH_W-1:0]       highBits   = wrData[HIGH_W-1:0] & CODE_HIGH_MASK;
			// The held low byte joins the high byte, so the output moves only once
			wire [CODE_WIDTH-1:0]   pairedCode = {highBits, lowByteHold[ch]};
			wire [DATA_WIDTH-1:0]   next_lowByte = clearState ? '0 :
			                                       wrLow      ? wrData :
			                                       lowByteHold[ch];
			wire [CODE_WIDTH-1:0]   next_code  = clearState ? CODE_DEFAULT :
			                                     wrHigh     ? pairedCode :
			                                     codeReg[ch];

			// Held low byte; a high byte alone reuses whatever is held
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					lowByteHold[ch] <= '0;
				end else if (ce) begin
					lowByteHold[ch] <= next_lowByte;
				end
			end

			// Output code of this channel
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					codeReg[ch] <= CODE_DEFAULT; // [RULE_02] [RULE_03]
				end else if (ce) begin
					codeReg[ch] <= next_code; // [RULE_01] [RULE_04]
				end
			end

			assign outCode[ch*CODE_WIDTH +: CODE_WIDTH] = codeReg[ch];
		end
	endgenerate

	// Unmapped and write-only offsets read as zero
	assign next_rdData = selCardId ? idReadValue : // [RULE_06]
	                     selRange  ? rangeSel :    // [RULE_09]
	                     '0;

	// Read data stands until the next accepted read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData <= '0;
		end else if (rdTaken) begin
			rdData <= next_rdData;
		end
	end

endmodule : board_id_and_reset_retention
